// File: common/stcc_pkg.sv
package stcc_pkg;

    // Register byte offsets on the APB word map
    localparam logic [7:0] OFF_RUN_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE_CTRL = 8'h04;
    localparam logic [7:0] OFF_CNT_LO = 8'h08;
    localparam logic [7:0] OFF_CNT_HI = 8'h0c;
    localparam logic [7:0] OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] OFF_CMPP = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1c;

    // Field positions
    localparam int RUN_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Counter limits
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [16:0] FULL_SPAN = 17'h10000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } stcc_mode_t;

    // Pin actions in compare mode
    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_LOW = 2'b01;
    localparam logic [1:0] ACT_HIGH = 2'b10;
    localparam logic [1:0] ACT_TOGGLE = 2'b11;

    // Pin actions in PWM / single pulse mode
    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'b00;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'b01;
    localparam logic [1:0] PWM_WAVE = 2'b10;
    localparam logic [1:0] PWM_SINGLE = 2'b11;

    // Mode control byte, bit 7 down to bit 0
    typedef struct packed {
        stcc_mode_t mode;
        logic [1:0] pin_action;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_select;
    } stcc_ctrl_t;

    localparam stcc_ctrl_t RST_CTRL = '{MODE_COMPARE, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// File: rtl/stcc_timer.sv
`timescale 1ns/1ps

module stcc_timer
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Count clock tick, same clock domain
    input wire logic count_tick_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Timer output pin
    output logic timer_output_pin_out,
    output logic timer_output_en_out,
    // Match flag levels
    output logic match_a_flag_out,
    output logic match_p_flag_out
);

    // Register state
    stcc_pkg::stcc_ctrl_t ctrl_q; // Mode control byte
    logic counter_run_q; // Run bit
    logic run_prev_q; // Run bit one cycle ago
    logic [15:0] cnt_q; // Counter
    logic [15:0] cmpa_q; // Compare-A value
    logic [7:0] cmpp_q; // Compare-P value
    logic flag_a_q; // Comparator A flag
    logic flag_p_q; // Comparator P flag
    logic pin_q; // Pin level before inversion
    logic pin_out_q; // Registered pin
    logic pin_en_q; // Registered pin enable
    logic [31:0] rdata_q; // Read data
    logic slverr_q; // Unmapped access answer

    // Combinational terms
    logic wr_en; // Write in access phase
    logic rd_setup; // Setup phase of any access
    logic run_rise; // Run bit rising edge
    logic tick_run; // Counting tick
    logic [15:0] cnt_inc; // Counter plus one
    logic hit_a; // Comparator A match
    logic hit_p; // Comparator P match or overflow
    logic clr_cnt; // Counter clear this tick
    logic single_mode; // Single pulse selected
    logic flag_p_allow; // P flag may be raised
    logic [16:0] duty_span; // PWM duty threshold
    logic pwm_active; // PWM waveform in active phase
    logic pin_d; // Next pin level
    logic drives_pin; // Mode owns the pin
    logic flag_wr; // Write to flag register

    // Map check, used for both write enable and error decode
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a[1:0] == 2'b00) && (a <= stcc_pkg::OFF_FLAGS);
    endfunction

    // Zero wait state: every access completes in its first access cycle
    assign pready_out = 1'b1;
    assign prdata_out = rdata_q;
    assign pslverr_out = slverr_q;
    assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0] && addr_mapped(paddr_in);
    assign rd_setup = psel_in && !penable_in;
    assign flag_wr = wr_en && (paddr_in == stcc_pkg::OFF_FLAGS);

    // Read data and error latched at setup so they stand through the access cycle
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (rd_setup)
        begin
            slverr_q <= !addr_mapped(paddr_in);
            rdata_q <= 32'h0000_0000;
            case (paddr_in)
                stcc_pkg::OFF_RUN_CTRL: rdata_q[stcc_pkg::RUN_BIT] <= counter_run_q;
                stcc_pkg::OFF_MODE_CTRL: rdata_q[7:0] <= ctrl_q;
                stcc_pkg::OFF_CNT_LO: rdata_q[7:0] <= cnt_q[7:0];
                stcc_pkg::OFF_CNT_HI: rdata_q[7:0] <= cnt_q[15:8];
                stcc_pkg::OFF_CMPA_LO: rdata_q[7:0] <= cmpa_q[7:0];
                stcc_pkg::OFF_CMPA_HI: rdata_q[7:0] <= cmpa_q[15:8];
                stcc_pkg::OFF_CMPP: rdata_q[7:0] <= cmpp_q;
                stcc_pkg::OFF_FLAGS:
                begin
                    rdata_q[stcc_pkg::FLAG_A_BIT] <= flag_a_q;
                    rdata_q[stcc_pkg::FLAG_P_BIT] <= flag_p_q;
                end
                // Unmapped reads return zero
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Mode control and compare registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_q <= stcc_pkg::RST_CTRL;
            cmpa_q <= stcc_pkg::RST_WORD;
            cmpp_q <= stcc_pkg::RST_BYTE;
        end
        else if (wr_en)
        begin
            // Compare-A of zero in compare mode is not guarded; software avoids it
            case (paddr_in)
                stcc_pkg::OFF_MODE_CTRL: ctrl_q <= stcc_pkg::stcc_ctrl_t'(pwdata_in[7:0]);
                stcc_pkg::OFF_CMPA_LO: cmpa_q[7:0] <= pwdata_in[7:0];
                stcc_pkg::OFF_CMPA_HI: cmpa_q[15:8] <= pwdata_in[7:0];
                stcc_pkg::OFF_CMPP: cmpp_q <= pwdata_in[7:0];
                // Other offsets hold no writable bits here
                default: ;
            endcase
        end
    end

    // Single pulse selected by PWM mode with pulse action
    assign single_mode = (ctrl_q.mode == stcc_pkg::MODE_PWM) && (ctrl_q.pin_action == stcc_pkg::PWM_SINGLE);

    // Run bit; an A match ends a single pulse unless software writes the bit that cycle
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            counter_run_q <= 1'b0;
            run_prev_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= counter_run_q;
            if (wr_en && (paddr_in == stcc_pkg::OFF_RUN_CTRL))
            begin
                counter_run_q <= pwdata_in[stcc_pkg::RUN_BIT];
            end
            else if (single_mode && hit_a)
            begin
                counter_run_q <= 1'b0;
            end
        end
    end

    assign run_rise = counter_run_q && !run_prev_q;
    assign tick_run = count_tick_in && counter_run_q && !run_rise;
    assign cnt_inc = cnt_q + 16'h0001;

    // Comparators look at the value the counter is about to take
    always_comb
    begin
        hit_a = tick_run && (cnt_inc == cmpa_q);
        if (cmpp_q == stcc_pkg::RST_BYTE)
        begin
            hit_p = tick_run && (cnt_q == stcc_pkg::CNT_MAX);
        end
        else
        begin
            hit_p = tick_run && (cnt_inc[15:8] == cmpp_q);
        end
    end

    // Counter clear source per mode
    always_comb
    begin
        case (ctrl_q.mode)
            stcc_pkg::MODE_COMPARE: clr_cnt = ctrl_q.clear_source_select ? hit_a : hit_p;
            stcc_pkg::MODE_TIMER: clr_cnt = ctrl_q.clear_source_select ? hit_a : hit_p;
            // Period comparator follows the swap bit, clear select ignored
            stcc_pkg::MODE_PWM: clr_cnt = single_mode ? 1'b0 : (ctrl_q.duty_period_swap ? hit_a : hit_p);
            stcc_pkg::MODE_CAPTURE: clr_cnt = hit_p;
            default: clr_cnt = 1'b0;
        endcase
    end

    // Counter: zeroed on run rise, held while stopped
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_q <= stcc_pkg::RST_WORD;
        end
        else if (run_rise)
        begin
            cnt_q <= stcc_pkg::RST_WORD;
        end
        else if (tick_run)
        begin
            cnt_q <= clr_cnt ? stcc_pkg::RST_WORD : cnt_inc;
        end
    end

    // With clear on A in compare/timer modes no P flag; none in single pulse either
    assign flag_p_allow = !(((ctrl_q.mode == stcc_pkg::MODE_COMPARE) || (ctrl_q.mode == stcc_pkg::MODE_TIMER))
        && ctrl_q.clear_source_select) && !single_mode;

    // Sticky flags, write one to clear; a new match wins over the clear
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end
        else
        begin
            if (hit_a)
            begin
                flag_a_q <= 1'b1;
            end
            else if (flag_wr && pwdata_in[stcc_pkg::FLAG_A_BIT])
            begin
                flag_a_q <= 1'b0;
            end
            if (hit_p && flag_p_allow)
            begin
                flag_p_q <= 1'b1;
            end
            else if (flag_wr && pwdata_in[stcc_pkg::FLAG_P_BIT])
            begin
                flag_p_q <= 1'b0;
            end
        end
    end

    assign match_a_flag_out = flag_a_q;
    assign match_p_flag_out = flag_p_q;

    // Duty threshold: compare-P of zero means the full span
    always_comb
    begin
        if (!ctrl_q.duty_period_swap)
        begin
            duty_span = {1'b0, cmpa_q};
        end
        else if (cmpp_q == stcc_pkg::RST_BYTE)
        begin
            duty_span = stcc_pkg::FULL_SPAN;
        end
        else
        begin
            duty_span = {1'b0, cmpp_q, 8'h00};
        end
    end

    // Duty at or above the period yields full duty
    assign pwm_active = ({1'b0, cnt_q} < duty_span);

    // Next pin level before inversion
    always_comb
    begin
        pin_d = pin_q;
        case (ctrl_q.mode)
            stcc_pkg::MODE_COMPARE:
            begin
                if (run_rise)
                begin
                    pin_d = ctrl_q.output_initial_level;
                end
                else if (hit_a)
                begin
                    case (ctrl_q.pin_action)
                        stcc_pkg::ACT_LOW: pin_d = 1'b0;
                        stcc_pkg::ACT_HIGH: pin_d = 1'b1;
                        stcc_pkg::ACT_TOGGLE: pin_d = !pin_q;
                        default: pin_d = pin_q;
                    endcase
                end
            end
            stcc_pkg::MODE_PWM:
            begin
                // Initial level is the active level here
                case (ctrl_q.pin_action)
                    stcc_pkg::PWM_FORCE_INACTIVE: pin_d = !ctrl_q.output_initial_level;
                    stcc_pkg::PWM_FORCE_ACTIVE: pin_d = ctrl_q.output_initial_level;
                    // Run rise restarts the period in its active phase, whatever count was left
                    stcc_pkg::PWM_WAVE: pin_d = (run_rise || pwm_active) ? ctrl_q.output_initial_level
                        : !ctrl_q.output_initial_level;
                    // Pulse active from run rise until run clears
                    stcc_pkg::PWM_SINGLE: pin_d = (run_rise || counter_run_q) ? ctrl_q.output_initial_level
                        : !ctrl_q.output_initial_level;
                    default: pin_d = pin_q;
                endcase
            end
            // Capture and timer modes leave the pin level alone
            default: pin_d = pin_q;
        endcase
    end

    // Output pin owned only by compare and PWM modes
    assign drives_pin = (ctrl_q.mode == stcc_pkg::MODE_COMPARE) || (ctrl_q.mode == stcc_pkg::MODE_PWM);

    // Pin registers; inversion applied last so it flips every waveform
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_q <= 1'b0;
            pin_out_q <= 1'b0;
            pin_en_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_d;
            pin_en_q <= drives_pin;
            pin_out_q <= drives_pin ? (pin_d ^ ctrl_q.output_invert) : 1'b0;
        end
    end

    assign timer_output_pin_out = pin_out_q;
    assign timer_output_en_out = pin_en_q;

    // Checks
    flag_a_set_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        hit_a |=> flag_a_q)
        else $error("A flag not set after match");

    flag_a_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (flag_a_q && !(flag_wr && pwdata_in[stcc_pkg::FLAG_A_BIT])) |=> flag_a_q)
        else $error("A flag dropped without clear");

    no_p_flag_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_COMPARE && ctrl_q.clear_source_select && !flag_p_q) |=> !flag_p_q)
        else $error("P flag raised with clear on A");

    run_rise_clr_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(counter_run_q) |=> (cnt_q == 16'h0000))
        else $error("Counter not zeroed on run rise");

    pin_init_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (run_rise && ctrl_q.mode == stcc_pkg::MODE_COMPARE) |=> (pin_q == $past(ctrl_q.output_initial_level)))
        else $error("Pin not loaded with initial level");

    pin_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_COMPARE && !hit_a && !run_rise) |=> $stable(pin_q))
        else $error("Pin moved without A match");

    pin_toggle_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_COMPARE && hit_a && !run_rise && ctrl_q.pin_action == stcc_pkg::ACT_TOGGLE)
        |=> (pin_q != $past(pin_q)))
        else $error("Pin did not toggle on A match");

    clear_on_a_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_COMPARE && ctrl_q.clear_source_select && hit_a) |=> (cnt_q == 16'h0000))
        else $error("Counter not cleared on A match");

    timer_pin_off_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_TIMER) |=> (!timer_output_en_out && !timer_output_pin_out))
        else $error("Pin driven in timer mode");

    pin_invert_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (ctrl_q.mode == stcc_pkg::MODE_COMPARE) |=> (timer_output_pin_out == (pin_q ^ $past(ctrl_q.output_invert))))
        else $error("Pin polarity wrong");

    count_inc_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (tick_run && !clr_cnt) |=> (cnt_q == $past(cnt_q) + 16'h0001))
        else $error("Counter did not advance on tick");

endmodule

// File: sim/stcc_timer_bench.sv
`timescale 1ns/1ps

module stcc_timer_bench;
    // Clock, reset and count tick
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic count_tick_in = 1'b0;
    // APB master side
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hf;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    // Pin and flags
    logic timer_output_pin_out;
    logic timer_output_en_out;
    logic match_a_flag_out;
    logic match_p_flag_out;
    // Score and scratch
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h53;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] wd;
    logic [15:0] cnt;
    logic [15:0] na;
    logic inv;
    stcc_pkg::stcc_ctrl_t ctl;

    // 25 MHz system clock
    always #20 clk_sys_in = ~clk_sys_in;

    stcc_timer u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .count_tick_in(count_tick_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .timer_output_pin_out(timer_output_pin_out),
        .timer_output_en_out(timer_output_en_out), .match_a_flag_out(match_a_flag_out),
        .match_p_flag_out(match_p_flag_out));

    // Xorshift source, fixed start so every run repeats
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Pin level after an A match in compare mode
    function automatic logic pin_after(input logic [1:0] act, input logic lvl);
        case (act)
            2'b01: return 1'b0;
            2'b10: return 1'b1;
            2'b11: return ~lvl;
            default: return lvl;
        endcase
    endfunction

    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pin(input logic exp);
        chk({31'h0, timer_output_pin_out}, {31'h0, exp});
    endtask

    task automatic flg(input logic [1:0] exp);
        chk({30'h0, match_p_flag_out, match_a_flag_out}, {30'h0, exp});
    endtask

    // One APB transfer; trailing idle edge keeps strobes from being reassigned in one step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= data;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1)
            @(posedge clk_sys_in);
        rdata = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    // Counter read as two bytes; ticks must be idle meanwhile
    task automatic chk_cnt(input logic [15:0] exp);
        apb(1'b0, stcc_pkg::OFF_CNT_LO, 32'h0);
        cnt[7:0] = rdata[7:0];
        apb(1'b0, stcc_pkg::OFF_CNT_HI, 32'h0);
        cnt[15:8] = rdata[7:0];
        chk({16'h0, cnt}, {16'h0, exp});
    endtask

    // Stop, clear flags, program, then restart so the run bit rises
    task automatic cfg(input stcc_pkg::stcc_ctrl_t c, input logic [15:0] a, input logic [7:0] p);
        apb(1'b1, stcc_pkg::OFF_RUN_CTRL, 32'h0);
        apb(1'b1, stcc_pkg::OFF_FLAGS, 32'h3);
        apb(1'b1, stcc_pkg::OFF_MODE_CTRL, {24'h0, c});
        apb(1'b1, stcc_pkg::OFF_CMPA_LO, {24'h0, a[7:0]});
        apb(1'b1, stcc_pkg::OFF_CMPA_HI, {24'h0, a[15:8]});
        apb(1'b1, stcc_pkg::OFF_CMPP, {24'h0, p});
        apb(1'b1, stcc_pkg::OFF_RUN_CTRL, 32'h1 << stcc_pkg::RUN_BIT);
        repeat (2) @(posedge clk_sys_in);
    endtask

    // Tick held for n cycles, then two idle edges to settle
    task automatic ticks(input int n);
        count_tick_in <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        count_tick_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        // Every mapped word reads zero after reset
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rdata, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({30'h0, pready_out, rerr}, 32'h3);
        // Counter bytes refuse writes, compare bytes keep them
        for (int i = 2; i < 7; i++)
        begin
            wd = rnd();
            apb(1'b1, 8'(i * 4), wd);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rdata, (i < 4) ? 32'h0 : {24'h0, wd[7:0]});
        end
        // All pin actions and levels, A clears, counter runs past the P point
        for (int k = 0; k < 8; k++)
        begin
            wd = rnd();
            inv = wd[0];
            na = 16'h0101 + {10'h0, wd[6:1]};
            ctl = '{stcc_pkg::MODE_COMPARE, 2'(k >> 1), k[0], inv, wd[7], 1'b1};
            cfg(ctl, na, 8'h01);
            pin(k[0] ^ inv);
            chk({31'h0, timer_output_en_out}, 32'h1);
            ticks(int'(na) - 1);
            chk_cnt(na - 16'h1);
            flg(2'b00);
            pin(k[0] ^ inv);
            ticks(1);
            chk_cnt(16'h0);
            flg(2'b01);
            pin(pin_after(2'(k >> 1), k[0]) ^ inv);
            ticks(5);
            flg(2'b01);
        end
        // Clear select low: P clears, A sets its flag and moves the pin
        ctl = '{stcc_pkg::MODE_COMPARE, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0};
        cfg(ctl, 16'h0064, 8'h01);
        ticks(100);
        chk_cnt(16'h0064);
        flg(2'b01);
        pin(1'b1);
        ticks(155);
        chk_cnt(16'h00ff);
        ticks(1);
        chk_cnt(16'h0);
        flg(2'b11);
        pin(1'b1);
        apb(1'b1, stcc_pkg::OFF_FLAGS, 32'h3);
        flg(2'b00);
        // Run fall holds the count, run rise zeroes it and restores the pin
        ticks(10);
        apb(1'b1, stcc_pkg::OFF_RUN_CTRL, 32'h0);
        ticks(20);
        chk_cnt(16'h000a);
        apb(1'b1, stcc_pkg::OFF_RUN_CTRL, 32'h1 << stcc_pkg::RUN_BIT);
        repeat (2) @(posedge clk_sys_in);
        chk_cnt(16'h0);
        pin(1'b0);
        // Zero compare-P: clear only on overflow, full span
        ctl = '{stcc_pkg::MODE_COMPARE, 2'b10, 1'b0, 1'b0, 1'b0, 1'b0};
        cfg(ctl, 16'hfff0, 8'h00);
        ticks(65535);
        chk_cnt(16'hffff);
        flg(2'b01);
        ticks(1);
        chk_cnt(16'h0);
        flg(2'b11);
        // Timer mode: flags as in compare, pin left alone
        ctl = '{stcc_pkg::MODE_TIMER, 2'b10, 1'b1, 1'b1, 1'b0, 1'b1};
        cfg(ctl, 16'h0005, 8'h01);
        chk({30'h0, timer_output_en_out, timer_output_pin_out}, 32'h0);
        ticks(5);
        flg(2'b01);
        chk_cnt(16'h0);
        chk({30'h0, timer_output_en_out, timer_output_pin_out}, 32'h0);
        // Capture mode clears on P even with clear select high
        ctl = '{stcc_pkg::MODE_CAPTURE, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1};
        cfg(ctl, 16'h000a, 8'h01);
        ticks(10);
        chk_cnt(16'h000a);
        ticks(246);
        chk_cnt(16'h0);
        // PWM, P sets period, A sets duty, both polarities
        for (int k = 0; k < 2; k++)
        begin
            ctl = '{stcc_pkg::MODE_PWM, 2'b10, 1'b1, k[0], 1'b0, 1'b1};
            cfg(ctl, 16'h0040, 8'h01);
            pin(~k[0]);
            ticks(63);
            pin(~k[0]);
            ticks(1);
            pin(k[0]);
            chk_cnt(16'h0040);
            ticks(192);
            pin(~k[0]);
            chk_cnt(16'h0);
        end
        // PWM swapped: A sets period, P sets duty, active low
        ctl = '{stcc_pkg::MODE_PWM, 2'b10, 1'b0, 1'b0, 1'b1, 1'b0};
        cfg(ctl, 16'h012c, 8'h01);
        pin(1'b0);
        ticks(256);
        pin(1'b1);
        ticks(44);
        chk_cnt(16'h0);
        pin(1'b0);
        // PWM forced levels: inactive then active, active high
        for (int k = 0; k < 2; k++)
        begin
            ctl = '{stcc_pkg::MODE_PWM, 2'(k), 1'b1, 1'b0, 1'b0, 1'b0};
            cfg(ctl, 16'h0040, 8'h01);
            pin(k[0]);
        end
        // Single pulse: leading edge on run rise, A match ends it
        ctl = '{stcc_pkg::MODE_PWM, 2'b11, 1'b1, 1'b0, 1'b0, 1'b0};
        cfg(ctl, 16'h0028, 8'h01);
        pin(1'b1);
        ticks(40);
        pin(1'b0);
        apb(1'b0, stcc_pkg::OFF_RUN_CTRL, 32'h0);
        chk(rdata, 32'h0);
        end_of_test();
    end

    // Watchdog above the roughly 70k cycles the sequence needs, under the run budget
    initial
    begin
        repeat (85000) @(posedge clk_sys_in);
        bad_count++;
        end_of_test();
    end
endmodule
